// ==== inc/analog_scan_defs.svh ====
`ifndef ANALOG_SCAN_DEFS_SVH
`define ANALOG_SCAN_DEFS_SVH

// ****************************************
// Register byte offsets and region numbers
// ****************************************
`define REG_CTRL 10'h000
`define REG_IN_USE 10'h004
`define REG_STATUS 10'h008
`define REG_MASK 10'h00c
`define REG_UNDER 10'h010
`define REG_OVER 10'h014
`define REG_TB 10'h018
`define REGION_VALUE 4'h1
`define REGION_CFG 4'h2
`define REGION_LO 4'h3
`define REGION_HI 4'h4

// ****************************************
// Field positions
// ****************************************
`define CTRL_FAST 0
`define CTRL_TBD_EN 1
`define CFG_FILT_LSB 0
`define CFG_FILT_MSB 2
`define CFG_LO_EN 8
`define CFG_HI_EN 9
`define ST_TB_ERR 0
`define ST_UNDER 1
`define ST_OVER 2
`define ST_SWEEP 3
`define ST_BITS 4

// ****************************************
// Parameter defaults and limits
// ****************************************
`define FILT_MAX 3'h6
`define NCH_DEF 8
`define NCONN_DEF 2
`define DW_DEF 16

// ****************************************
// Timing
// ****************************************
`define CLK_PERIOD_NS 20
`define SLOT_TIME_NS 1000
`define SCAN_TIME_NS 10000
`define SLOT_CYCLES ((`SLOT_TIME_NS) / (`CLK_PERIOD_NS))
`define SCAN_CYCLES ((`SCAN_TIME_NS) / (`CLK_PERIOD_NS))

`endif

// ==== inc/analog_scan_pkg.sv ====
package analog_scan_pkg;
  typedef enum logic [1:0] {
    SQ_IDLE,
    SQ_REQ,
    SQ_SLOT
  } scan_state_t;
endpackage : analog_scan_pkg

// ==== rtl/analog_input_channel_scan.sv ====
`timescale 1ns/1ps
`include "analog_scan_defs.svh"
// Behaviour
// R1: filter setting 0..6, none/low/medium/high depth
// R2: fast scan bypasses filtering entirely
// R3: normal scan samples all channels per period
// R4: fast scan samples in-use channels, slot each
// R5: values refreshed at task start, then stable
// R6: detection enabled flags missing terminal block
// R7: two connectors: error only if serving used
// R8: unused channel reads zero, status inactive
// R9: used channel returns its measured value
// R10: independent underflow and overflow enables
// R11: flags when value crosses monitored threshold
module analog_input_channel_scan
  import analog_scan_pkg::*;
#(
  parameter int NCH = `NCH_DEF,
  parameter int NCONN = `NCONN_DEF,
  parameter int DW = `DW_DEF,
  parameter int SLOT_CYC = `SLOT_CYCLES,
  parameter int SCAN_CYC = `SCAN_CYCLES
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [9:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic conv_start,
  output logic [$clog2(NCH)-1:0] conv_chan,
  input wire logic conv_done,
  input wire logic [DW-1:0] conv_data,
  input wire logic task_start,
  input wire logic [NCONN-1:0] tb_present,
  output logic tb_error,
  output logic irq
);
  localparam int CW = $clog2(NCH);
  localparam int CNTW = 16;

  // ****************************************
  // State
  // ****************************************
  logic ack_q;
  logic [31:0] dat_q;
  logic fast_q;
  logic tbd_en_q;
  logic [NCH-1:0] in_use_q;
  logic [NCH-1:0] lo_en_q;
  logic [NCH-1:0] hi_en_q;
  logic [2:0] filt_set_q [NCH];
  logic signed [DW-1:0] lo_th_q [NCH];
  logic signed [DW-1:0] hi_th_q [NCH];
  logic signed [DW-1:0] filt_q [NCH];
  logic signed [DW-1:0] val_q [NCH];
  logic [NCH-1:0] under_q;
  logic [NCH-1:0] over_q;
  logic [`ST_BITS-1:0] status_q;
  logic [`ST_BITS-1:0] mask_q;
  logic tb_err_q;
  scan_state_t state_q;
  logic [CW-1:0] idx_q;
  logic [CNTW-1:0] slot_cnt_q;
  logic [CNTW-1:0] per_cnt_q;
  logic signed [DW-1:0] samp_q;
  logic got_q;

  // ****************************************
  // Bus decode
  // ****************************************
  wire req = wb_cyc_i & wb_stb_i;
  wire wr = req & wb_we_i & ack_q;
  wire rd_done = req & ~wb_we_i & ack_q;
  wire [3:0] region = wb_adr_i[9:6];
  wire [CW-1:0] widx = wb_adr_i[CW+1:2];
  wire idx_ok = ({28'h0, wb_adr_i[5:2]} < NCH);
  wire [31:0] wm = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
                    {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  wire is_ctrl = (wb_adr_i == `REG_CTRL);
  wire is_use = (wb_adr_i == `REG_IN_USE);
  wire is_stat = (wb_adr_i == `REG_STATUS);
  wire is_mask = (wb_adr_i == `REG_MASK);
  wire is_cfg = (region == `REGION_CFG) && idx_ok;
  wire is_lo = (region == `REGION_LO) && idx_ok;
  wire is_hi = (region == `REGION_HI) && idx_ok;
  wire [31:0] cfg_word = {22'h0, hi_en_q[widx], lo_en_q[widx],
                          5'h0, filt_set_q[widx]};
  wire [31:0] rdata =
    is_ctrl ? {30'h0, tbd_en_q, fast_q} :
    is_use ? 32'(in_use_q) :
    is_stat ? 32'(status_q) :
    is_mask ? 32'(mask_q) :
    (wb_adr_i == `REG_UNDER) ? 32'(under_q) :
    (wb_adr_i == `REG_OVER) ? 32'(over_q) :
    (wb_adr_i == `REG_TB) ? {31'h0, tb_err_q} :
    (region == `REGION_VALUE && idx_ok) ? 32'(unsigned'(val_q[widx])) :
    is_cfg ? cfg_word :
    is_lo ? 32'(unsigned'(lo_th_q[widx])) :
    is_hi ? 32'(unsigned'(hi_th_q[widx])) :
    32'h0;

  // Byte lanes not selected keep their old contents.
  wire [31:0] wdat = (rdata & ~wm) | (wb_dat_i & wm);
  wire [2:0] wfilt = wdat[`CFG_FILT_MSB:`CFG_FILT_LSB];

  always_ff @(posedge clk) begin
    if (!nrst) begin
      ack_q <= 1'b0;
      dat_q <= 32'h0;
    end else begin
      ack_q <= req & ~ack_q;
      if (req & ~ack_q) begin
        dat_q <= rdata;
      end
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = dat_q;

  // ****************************************
  // Configuration registers
  // ****************************************
  always_ff @(posedge clk) begin
    if (!nrst) begin
      fast_q <= 1'b0;
      tbd_en_q <= 1'b0;
      in_use_q <= '1;
      mask_q <= '0;
      lo_en_q <= '0;
      hi_en_q <= '0;
      for (int i = 0; i < NCH; i++) begin
        filt_set_q[i] <= 3'h0;
        lo_th_q[i] <= '0;
        hi_th_q[i] <= '0;
      end
    end else if (wr) begin
      if (is_ctrl) begin
        fast_q <= wdat[`CTRL_FAST];
        tbd_en_q <= wdat[`CTRL_TBD_EN];
      end
      if (is_use) begin
        in_use_q <= wdat[NCH-1:0];
      end
      if (is_mask) begin
        mask_q <= wdat[`ST_BITS-1:0];
      end
      if (is_cfg) begin
        // Out-of-range settings saturate at the deepest filter.
        filt_set_q[widx] <= (wfilt > `FILT_MAX) ? `FILT_MAX : wfilt; // R1
        lo_en_q[widx] <= wdat[`CFG_LO_EN]; // R10
        hi_en_q[widx] <= wdat[`CFG_HI_EN]; // R10
      end
      if (is_lo) begin
        lo_th_q[widx] <= wdat[DW-1:0];
      end
      if (is_hi) begin
        hi_th_q[widx] <= wdat[DW-1:0];
      end
    end
  end

  // ****************************************
  // Scan sequencer
  // ****************************************
  function automatic logic [CW:0] next_ch(input logic [NCH-1:0] m,
                                          input int after);
    logic [CW:0] r;
    r = '0;
    for (int i = NCH - 1; i >= 0; i--) begin
      if (i > after && m[i]) begin
        r = {1'b1, CW'(i)};
      end
    end
    return r;
  endfunction : next_ch

  wire [NCH-1:0] scan_mask = fast_q ? in_use_q : '1; // R3 R4
  wire [CW:0] first = next_ch(scan_mask, -1);
  wire [CW:0] after = next_ch(scan_mask, int'(idx_q));
  wire tick = (per_cnt_q == '0);
  // Fast mode restarts at once, so its period is used count times slot.
  wire go = first[CW] & (fast_q | tick); // R3 R4
  wire more = after[CW] | (fast_q & first[CW]); // R4
  wire slot_end = (state_q == SQ_SLOT) && (slot_cnt_q == '0);
  wire sweep_done = slot_end & ~after[CW];

  // Filter: first order low pass, deeper shift for higher settings.
  wire [2:0] k = fast_q ? 3'h0 : filt_set_q[idx_q]; // R1 R2
  wire signed [DW-1:0] cur = filt_q[idx_q];
  wire got = got_q | conv_done;
  wire signed [DW-1:0] smp = conv_done ? conv_data : samp_q;
  wire signed [DW:0] diff = {smp[DW-1], smp} - {cur[DW-1], cur};
  wire signed [DW:0] step = diff >>> k;
  wire signed [DW-1:0] newv = (k == 3'h0) ? smp :
                              DW'(cur + step[DW-1:0]); // R1 R2

  always_ff @(posedge clk) begin
    if (!nrst) begin
      state_q <= SQ_IDLE;
      idx_q <= '0;
      slot_cnt_q <= '0;
      per_cnt_q <= '0;
      samp_q <= '0;
      got_q <= 1'b0;
    end else begin
      per_cnt_q <= tick ? CNTW'(SCAN_CYC - 1) : per_cnt_q - 1'b1; // R3
      unique case (state_q)
        SQ_IDLE: begin
          if (go) begin
            idx_q <= first[CW-1:0];
            state_q <= SQ_REQ;
          end
        end
        SQ_REQ: begin
          slot_cnt_q <= CNTW'(SLOT_CYC - 2);
          got_q <= 1'b0;
          state_q <= SQ_SLOT;
        end
        SQ_SLOT: begin
          slot_cnt_q <= slot_cnt_q - 1'b1;
          if (conv_done) begin
            samp_q <= conv_data;
            got_q <= 1'b1;
          end
          if (slot_end) begin
            idx_q <= after[CW] ? after[CW-1:0] : first[CW-1:0];
            state_q <= more ? SQ_REQ : SQ_IDLE; // R4
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      for (int i = 0; i < NCH; i++) begin
        filt_q[i] <= '0;
      end
    end else if (slot_end && got) begin
      filt_q[idx_q] <= newv;
    end
  end

  assign conv_start = (state_q == SQ_REQ);
  assign conv_chan = idx_q;

  // ****************************************
  // Task refresh and thresholds
  // ****************************************
  logic [NCH-1:0] under_d;
  logic [NCH-1:0] over_d;

  always_comb begin
    for (int i = 0; i < NCH; i++) begin
      under_d[i] = in_use_q[i] & lo_en_q[i] &
                   (filt_q[i] < lo_th_q[i]); // R8 R10 R11
      over_d[i] = in_use_q[i] & hi_en_q[i] &
                  (filt_q[i] > hi_th_q[i]); // R8 R10 R11
    end
  end

  // Values only move on a task start, so a task cycle sees one snapshot.
  always_ff @(posedge clk) begin
    if (!nrst) begin
      under_q <= '0;
      over_q <= '0;
      for (int i = 0; i < NCH; i++) begin
        val_q[i] <= '0;
      end
    end else if (task_start) begin // R5
      under_q <= under_d;
      over_q <= over_d;
      for (int i = 0; i < NCH; i++) begin
        val_q[i] <= in_use_q[i] ? filt_q[i] : '0; // R8 R9
      end
    end
  end

  // ****************************************
  // Terminal block detection
  // ****************************************
  logic [NCH-1:0] chan_missing;

  always_comb begin
    for (int i = 0; i < NCH; i++) begin
      chan_missing[i] = ~tb_present[(i * NCONN) / NCH];
    end
  end

  // A single connector is checked whatever the channel usage.
  wire [NCH-1:0] tb_gate = (NCONN > 1) ? in_use_q : '1; // R7
  wire tb_err_d = tbd_en_q & |(chan_missing & tb_gate); // R6 R7

  always_ff @(posedge clk) begin
    if (!nrst) begin
      tb_err_q <= 1'b0;
    end else begin
      tb_err_q <= tb_err_d;
    end
  end

  assign tb_error = tb_err_q;

  // ****************************************
  // Interrupt status
  // ****************************************
  logic [`ST_BITS-1:0] evt;

  always_comb begin
    evt = '0;
    evt[`ST_TB_ERR] = tb_err_d & ~tb_err_q;
    evt[`ST_UNDER] = task_start & |under_d;
    evt[`ST_OVER] = task_start & |over_d;
    evt[`ST_SWEEP] = sweep_done;
  end

  wire st_clr = rd_done & is_stat;

  // A read clears only the bits it returned, so no event is lost.
  always_ff @(posedge clk) begin
    if (!nrst) begin
      status_q <= '0;
    end else begin
      status_q <= (st_clr ? status_q & ~dat_q[`ST_BITS-1:0] : status_q) | evt;
    end
  end

  assign irq = |(status_q & mask_q);
endmodule : analog_input_channel_scan

// ==== verification/analog_scan_asserts.sv ====
`timescale 1ns/1ps
module analog_scan_asserts #(
  parameter int NCH = 8,
  parameter int NCONN = 2
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic conv_start,
  input wire logic [$clog2(NCH)-1:0] conv_chan,
  input wire logic [NCONN-1:0] tb_present,
  input wire logic tb_error,
  input wire logic irq
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (!nrst);

  ack_wait_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack late");
  ack_once_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  ack_cause_a: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  dat_hold_a: assert property ($changed(wb_dat_o) |-> wb_ack_o)
    else $error("read data moved outside an access");
  slot_gap_a: assert property (conv_start |=> !conv_start [*3])
    else $error("slot cut short");
  chan_hold_a: assert property (conv_start |=> $stable(conv_chan) [*3])
    else $error("channel moved inside a slot");
  tb_clear_a: assert property (&tb_present |=> !tb_error)
    else $error("terminal error with all present");
  tb_cause_a: assert property ($rose(tb_error) |-> !$past(&tb_present))
    else $error("terminal error without missing connector");

  cover property (conv_start ##4 conv_start);
  cover property ($rose(tb_error));
  cover property ($rose(irq));
endmodule : analog_scan_asserts

bind analog_input_channel_scan analog_scan_asserts #(
  .NCH(NCH), .NCONN(NCONN)) chk_i (
  .clk(clk), .nrst(nrst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .conv_start(conv_start),
  .conv_chan(conv_chan), .tb_present(tb_present), .tb_error(tb_error),
  .irq(irq));

// ==== verification/conv_model.sv ====
`timescale 1ns/1ps
module conv_model #(
  parameter int DW = 16,
  parameter int CW = 3
) (
  input wire logic clk,
  input wire logic conv_start,
  input wire logic [CW-1:0] conv_chan,
  input wire logic [DW-1:0] level,
  output logic conv_done,
  output logic [DW-1:0] conv_data
);
  logic late_q;
  logic fire;

  // Even channels answer the cycle after the start, odd ones a cycle later.
  assign fire = (conv_start && !conv_chan[0]) || late_q;

  initial begin
    late_q = 1'b0;
    conv_done = 1'b0;
    conv_data = '0;
  end

  // Data toggles outside the strobe so a stale capture shows up.
  always @(posedge clk) begin
    late_q <= conv_start && conv_chan[0];
    conv_done <= fire;
    conv_data <= fire ? level + DW'(conv_chan) : ~conv_data;
  end
endmodule : conv_model

// ==== verification/testbench.sv ====
`timescale 1ns/1ps
`include "analog_scan_defs.svh"
module testbench;
  logic clk, nrst, cyc, stb, we, ts, ack, done, irq, tbe, cs;
  logic [9:0] adr;
  logic [31:0] wdat, rdat, q;
  logic [2:0] ch;
  logic [15:0] lvl, cdat;
  logic [1:0] pres;
  logic [3:0] sel;
  logic [7:0] use_v;
  int mismatches, checks_done, starts, bad, ticks;

  analog_input_channel_scan #(.SLOT_CYC(4), .SCAN_CYC(64)) dut (
    .clk(clk), .nrst(nrst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .conv_start(cs), .conv_chan(ch), .conv_done(done),
    .conv_data(cdat), .task_start(ts), .tb_present(pres),
    .tb_error(tbe), .irq(irq));
  conv_model #(.DW(16), .CW(3)) conv (.clk(clk), .conv_start(cs),
    .conv_chan(ch), .level(lvl), .conv_done(done), .conv_data(cdat));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // ****
  // Common tasks
  // ****
  always @(posedge clk) begin
    ticks <= ticks + 1;
    if (cs === 1'b1) begin
      starts <= starts + 1;
      bad <= bad + int'(!use_v[ch]);
    end
    if (ticks == 20000) begin
      mismatches++;
      complete_run;
    end
  end

  task complete_run;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : complete_run

  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task bus(input logic w, input logic [9:0] a, input logic [31:0] d);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge clk);
    end while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
  endtask : bus

  task rd(input logic [9:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk($sformatf("reg %h", a), e, q);
  endtask : rd

  task tstart;
    ts <= 1'b1;
    @(posedge clk);
    ts <= 1'b0;
    @(posedge clk);
  endtask : tstart

  task cnt(input int n, input int es, input int eb);
    int s0, b0;
    s0 = starts;
    b0 = bad;
    repeat (n) @(posedge clk);
    chk("starts", es, starts - s0);
    chk("unused starts", eb, bad - b0);
  endtask : cnt

  // ****
  // Scenarios
  // ****
  task t_use;
    bus(1'b1, `REG_IN_USE, 32'h05);
    use_v <= 8'h05;
    repeat (140) @(posedge clk);
    tstart;
    for (int n = 0; n < 4; n++)
      rd(10'h040 + 10'(4 * n), use_v[n] ? 32'h100 + n : 32'h0);
    lvl <= 16'h0200;
    repeat (140) @(posedge clk);
    rd(10'h040, 32'h100);
  endtask : t_use

  task t_filt;
    bus(1'b1, 10'h080, 32'h7);
    rd(10'h080, 32'h6);
    lvl <= 16'h1200;
    repeat (20) @(posedge clk);
    tstart;
    rd(10'h040, 32'h1200);
    bus(1'b1, `REG_CTRL, 32'h0);
    lvl <= 16'h2200;
    repeat (140) @(posedge clk);
    tstart;
    bus(1'b0, 10'h040, 32'h0);
    chk("filtered", 1, q > 32'h1200 && q < 32'h2200);
  endtask : t_filt

  task t_thr;
    bus(1'b1, 10'h0c8, 32'h2203);
    bus(1'b1, 10'h108, 32'h2201);
    bus(1'b1, 10'h088, 32'h100);
    bus(1'b1, 10'h084, 32'h300);
    bus(1'b1, 10'h0c4, 32'h7fff);
    bus(1'b1, `REG_MASK, 32'h2);
    tstart;
    rd(`REG_UNDER, 32'h4);
    rd(`REG_OVER, 32'h0);
    chk("irq", 1, irq);
    bus(1'b0, `REG_STATUS, 32'h0);
    chk("status", 32'ha, q);
    chk("irq", 0, irq);
    bus(1'b1, 10'h088, 32'h200);
    tstart;
    rd(`REG_UNDER, 32'h0);
    rd(`REG_OVER, 32'h4);
    chk("irq", 0, irq);
  endtask : t_thr

  task t_term;
    bus(1'b1, `REG_CTRL, 32'h2);
    pres <= 2'b10;
    repeat (3) @(posedge clk);
    chk("tb_error", 1, tbe);
    bus(1'b1, `REG_IN_USE, 32'hf0);
    use_v <= 8'hf0;
    repeat (3) @(posedge clk);
    chk("tb_error", 0, tbe);
    pres <= 2'b01;
    repeat (3) @(posedge clk);
    chk("tb_error", 1, tbe);
    bus(1'b1, `REG_CTRL, 32'h0);
    repeat (3) @(posedge clk);
    chk("tb_error", 0, tbe);
  endtask : t_term

  initial begin
    {nrst, cyc, stb, we, ts, adr, wdat} = '0;
    lvl = 16'h0100;
    pres = 2'h3;
    sel = 4'hf;
    use_v = 8'hff;
    {mismatches, checks_done, starts, bad, ticks} = '0;
    repeat (5) @(posedge clk);
    nrst <= 1'b1;
    rd(`REG_IN_USE, 32'hff);
    rd(`REG_CTRL, 32'h0);
    rd(`REG_MASK, 32'h0);
    rd(10'h3fc, 32'h0);
    bus(1'b1, 10'h0cc, 32'h1234);
    sel <= 4'h1;
    bus(1'b1, 10'h0cc, 32'hffff_ff56);
    sel <= 4'hf;
    rd(10'h0cc, 32'h1256);
    t_use;
    cnt(128, 16, 12);
    bus(1'b1, `REG_CTRL, 32'h1);
    repeat (40) @(posedge clk);
    cnt(88, 22, 0);
    t_filt;
    t_thr;
    t_term;
    complete_run;
  end
endmodule : testbench
